/* rtl/lcr_params.svh */
`ifndef LCR_PARAMS_SVH
`define LCR_PARAMS_SVH
// -------------------------------------------------------------
// Offsets, field positions and reset values
// -------------------------------------------------------------
`define LCR_OFS_PATTERN_RX_EQ 4'h0
`define LCR_OFS_TERM_JITTER 4'h1
`define LCR_CHAN_SHIFT 4
`define LCR_RESET_PATTERN_RX_EQ 8'h00
`define LCR_RESET_TERM_JITTER 8'h00
`define LCR_BIT_PATTERN_KIND 7
`define LCR_BIT_PATTERN_ROUTE 6
`define LCR_BIT_RX_POWER 5
`define LCR_EQ_MSB 4
`define LCR_BIT_RX_TERM 7
`define LCR_BIT_TX_TERM 6
`define LCR_IMP_MSB 5
`define LCR_IMP_LSB 4
`define LCR_JA_MSB 3
`define LCR_JA_LSB 2
`define LCR_EQ_T1_FIRST 5'h08
`define LCR_EQ_T1_LAST 5'h0C
`define LCR_EQ_T1_ARB 5'h0D
`define LCR_EQ_E1_COAX 5'h1C
`define LCR_EQ_E1_PAIR 5'h1D
`endif

/* rtl/lcr_pkg.sv */
package lcr_pkg;
  // Decoded line mode per channel
  typedef enum logic [1:0] {
    LCR_MODE_T1, LCR_MODE_E1
  } lcr_line_e;
  typedef enum logic [1:0] {
    LCR_IMP_100, LCR_IMP_110, LCR_IMP_75, LCR_IMP_120
  } lcr_imp_e;
  typedef enum logic [1:0] {
    LCR_JA_OFF, LCR_JA_TX, LCR_JA_RX
  } lcr_ja_e;
  // Per-channel decoded line configuration
  typedef struct packed {
    logic rx_power;
    logic rx_term;
    logic tx_term;
    lcr_line_e line_mode;
    logic [2:0] lbo_step;   // 0..4 cable ranges, 5 arbitrary
    logic coax;
    logic hdb3;
    logic eq_reserved;
    lcr_imp_e rx_imp;
    lcr_ja_e ja_path;
  } lcr_chan_cfg_s;
endpackage : lcr_pkg

/* rtl/lcr_regs.sv */
`timescale 1ns/1ps
`include "lcr_params.svh"
// What this block does
// - Pattern kind bit 7: one quasi-random, zero pseudo-random sequence.
// - Route bit zero sends generator output to transmit tip and ring.
// - Route bit one drives generator on rx positive, rx negative low.
// - Receiver power bit resets to zero; one turns receiver on.
// - Receiver power only takes effect while global enable pin high.
// - Codes 08-0C pick T1 short-haul ranges, 0D arbitrary pulse.
// - Five-bit code picks mode and cable; 1C E1 coax, 1D E1 pair.
// - Receive termination resets high impedance; one gives internal.
// - Transmit termination resets high impedance; one gives internal.
// - Impedance field: 00 100, 01 110, 10 75, 11 120 ohm.
// - Jitter field: 00 off, 01 transmit, 10 and 11 receive path.
module lcr_regs import lcr_pkg::*; #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Host register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Global receiver enable pin (asynchronous)
  input wire logic rx_global_enable_i,
  // Pattern generator, per channel
  input wire logic [NUM_CH-1:0] pattern_enable_i,
  input wire logic [NUM_CH-1:0] pattern_bit_i,
  input wire logic [NUM_CH-1:0] tx_data_i,
  input wire logic [NUM_CH-1:0] rx_pos_data_i,
  input wire logic [NUM_CH-1:0] rx_neg_data_i,
  // Line and receive data outputs
  output logic [NUM_CH-1:0] tx_line_tip_o,
  output logic [NUM_CH-1:0] tx_line_ring_o,
  output logic [NUM_CH-1:0] rx_positive_data_o,
  output logic [NUM_CH-1:0] rx_negative_data_o,
  output logic [NUM_CH-1:0] pattern_kind_select_o,
  // Decoded analogue controls
  output lcr_chan_cfg_s [NUM_CH-1:0] chan_cfg_o
);

  // -----------------------------------------------------------
  // Register storage
  // -----------------------------------------------------------
  logic [7:0] reg0_r [NUM_CH];
  logic [7:0] reg1_r [NUM_CH];
  logic [7:0] reg0_nxt [NUM_CH];
  logic [7:0] reg1_nxt [NUM_CH];
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] rxen_sync_r, rxen_sync_nxt;
  logic rxen_r, rxen_nxt;
  logic [NUM_CH-1:0] tip_r, tip_nxt, ring_r, ring_nxt;
  logic [NUM_CH-1:0] rx_positive_data_r, rx_positive_data_nxt, rx_negative_data_r, rx_negative_data_nxt, kind_r, kind_nxt;
  lcr_chan_cfg_s [NUM_CH-1:0] cfg_r, cfg_nxt;

  // -----------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------
  // Channel index from the address; upper half is unmapped with eight channels
  function automatic logic chan_hit(input logic [7:0] a, input int ch,
                                    input logic [3:0] ofs);
    chan_hit = (a[7:`LCR_CHAN_SHIFT] == 4'(ch)) &&
               (a[`LCR_CHAN_SHIFT-1:0] == ofs);
  endfunction : chan_hit

  // -----------------------------------------------------------
  // Host access
  // -----------------------------------------------------------
  // Host writes and read-back
  always_comb begin
    rdata_nxt = rdata_r;
    for (int c = 0; c < NUM_CH; c++) begin
      reg0_nxt[c] = reg0_r[c];
      reg1_nxt[c] = reg1_r[c];
      if (reg_wr_i && chan_hit(reg_addr_i, c, `LCR_OFS_PATTERN_RX_EQ)) begin
        reg0_nxt[c] = reg_wdata_i;
      end
      if (reg_wr_i && chan_hit(reg_addr_i, c, `LCR_OFS_TERM_JITTER)) begin
        reg1_nxt[c] = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      rdata_nxt = 8'h00;  // Unmapped reads give zero
      for (int c = 0; c < NUM_CH; c++) begin
        if (chan_hit(reg_addr_i, c, `LCR_OFS_PATTERN_RX_EQ)) begin
          rdata_nxt = reg0_r[c];
        end
        if (chan_hit(reg_addr_i, c, `LCR_OFS_TERM_JITTER)) begin
          rdata_nxt = reg1_r[c];
        end
      end
    end
  end

  // -----------------------------------------------------------
  // Pin synchroniser
  // -----------------------------------------------------------
  // Three-stage sync of the pin; a change counts when stages 2,3 agree
  always_comb begin
    rxen_sync_nxt = {rxen_sync_r[1:0], rx_global_enable_i};
    rxen_nxt = rxen_r;
    if (rxen_sync_r[2] == rxen_sync_r[1]) begin
      rxen_nxt = rxen_sync_r[2];
    end
  end

  // -----------------------------------------------------------
  // Equalizer decode
  // -----------------------------------------------------------
  // Equalizer decode; reserved codes fall back to the first T1 range
  function automatic void eq_decode(input logic [4:0] eq,
                                    output lcr_line_e mode,
                                    output logic [2:0] step,
                                    output logic coax, output logic hdb3,
                                    output logic rsvd);
    mode = LCR_MODE_T1;
    step = 3'h0;
    coax = 1'b0;
    hdb3 = 1'b0;
    rsvd = 1'b0;
    if (eq >= `LCR_EQ_T1_FIRST && eq <= `LCR_EQ_T1_ARB) begin
      step = 3'(eq - `LCR_EQ_T1_FIRST);
    end else if (eq == `LCR_EQ_E1_COAX) begin
      mode = LCR_MODE_E1;
      coax = 1'b1;
      hdb3 = 1'b1;
    end else if (eq == `LCR_EQ_E1_PAIR) begin
      mode = LCR_MODE_E1;
      hdb3 = 1'b1;
    end else begin
      rsvd = 1'b1;
    end
  endfunction : eq_decode

  // -----------------------------------------------------------
  // Channel decode
  // -----------------------------------------------------------
  // Per-channel decode and pattern routing
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      cfg_nxt[c].rx_power = reg0_r[c][`LCR_BIT_RX_POWER] & rxen_r;
      cfg_nxt[c].rx_term = reg1_r[c][`LCR_BIT_RX_TERM];
      cfg_nxt[c].tx_term = reg1_r[c][`LCR_BIT_TX_TERM];
      eq_decode(reg0_r[c][`LCR_EQ_MSB:0], cfg_nxt[c].line_mode,
                cfg_nxt[c].lbo_step, cfg_nxt[c].coax, cfg_nxt[c].hdb3,
                cfg_nxt[c].eq_reserved);
      cfg_nxt[c].rx_imp =
        lcr_imp_e'(reg1_r[c][`LCR_IMP_MSB:`LCR_IMP_LSB]);
      case (reg1_r[c][`LCR_JA_MSB:`LCR_JA_LSB])
        2'b00: cfg_nxt[c].ja_path = LCR_JA_OFF;
        2'b01: cfg_nxt[c].ja_path = LCR_JA_TX;
        default: cfg_nxt[c].ja_path = LCR_JA_RX;
      endcase
      kind_nxt[c] = reg0_r[c][`LCR_BIT_PATTERN_KIND];
      tip_nxt[c] = tx_data_i[c];
      ring_nxt[c] = ~tx_data_i[c];
      rx_positive_data_nxt[c] = rx_pos_data_i[c];
      rx_negative_data_nxt[c] = rx_neg_data_i[c];
      // Route bit is ignored without pattern enable, tolerating misuse
      if (pattern_enable_i[c]) begin
        if (!reg0_r[c][`LCR_BIT_PATTERN_ROUTE]) begin
          tip_nxt[c] = pattern_bit_i[c];
          ring_nxt[c] = ~pattern_bit_i[c];
        end else begin
          rx_positive_data_nxt[c] = pattern_bit_i[c];
          rx_negative_data_nxt[c] = 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------
  // Registers
  // -----------------------------------------------------------
  // Host storage; reset leaves receivers off and terminations open
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        reg0_r[c] <= `LCR_RESET_PATTERN_RX_EQ;
        reg1_r[c] <= `LCR_RESET_TERM_JITTER;
      end
      rdata_r <= 8'h00;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        reg0_r[c] <= reg0_nxt[c];
        reg1_r[c] <= reg1_nxt[c];
      end
      rdata_r <= rdata_nxt;
    end
  end

  // Synchroniser cleared so the pin must be seen high again after reset
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rxen_sync_r <= 3'h0;
      rxen_r <= 1'b0;
    end else begin
      rxen_sync_r <= rxen_sync_nxt;
      rxen_r <= rxen_nxt;
    end
  end

  // Decoded controls and line data, one cycle behind their inputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_r <= '0;
      tip_r <= '0;
      ring_r <= '0;
      rx_positive_data_r <= '0;
      rx_negative_data_r <= '0;
      kind_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      tip_r <= tip_nxt;
      ring_r <= ring_nxt;
      rx_positive_data_r <= rx_positive_data_nxt;
      rx_negative_data_r <= rx_negative_data_nxt;
      kind_r <= kind_nxt;
    end
  end

  // -----------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------
  // Every output comes straight from a flip-flop, so no glitches
  assign reg_rdata_o = rdata_r;
  assign chan_cfg_o = cfg_r;
  assign tx_line_tip_o = tip_r;
  assign tx_line_ring_o = ring_r;
  assign rx_positive_data_o = rx_positive_data_r;
  assign rx_negative_data_o = rx_negative_data_r;
  assign pattern_kind_select_o = kind_r;

endmodule : lcr_regs

/* test/lcr_regs_asserts.sv */
`timescale 1ns/1ps
module lcr_regs_asserts import lcr_pkg::*; #(
  parameter int NUM_CH = 8
) (
  // Clock, reset and host writes
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // Pin, pattern and line side
  input wire logic rx_global_enable_i,
  input wire logic [NUM_CH-1:0] pattern_enable_i,
  input wire logic [NUM_CH-1:0] pattern_bit_i,
  input wire logic [NUM_CH-1:0] tx_line_tip_o,
  input wire logic [NUM_CH-1:0] rx_positive_data_o,
  input wire logic [NUM_CH-1:0] rx_negative_data_o,
  input wire lcr_chan_cfg_s [NUM_CH-1:0] chan_cfg_o
);
  // Channel 0 shadow; checks wait for three equal samples so that
  // either pipeline depth of the decode is accepted
  logic [7:0] s0_r, s1_r, a0_r, a1_r, b0_r, b1_r;
  logic [2:0] v_r;
  logic st0, st1;
  lcr_chan_cfg_s c0;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      {s0_r, s1_r, a0_r, a1_r, b0_r, b1_r, v_r} <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h00) s0_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h01) s1_r <= reg_wdata_i;
      {a0_r, a1_r, b0_r, b1_r} <= {s0_r, s1_r, a0_r, a1_r};
      v_r <= {v_r[1:0], 1'b1};
    end
  end
  assign st0 = v_r[2] && s0_r == a0_r && a0_r == b0_r;
  assign st1 = v_r[2] && s1_r == a1_r && a1_r == b1_r;
  assign c0 = chan_cfg_o[0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_route_line: assert property (st0 && !s0_r[6] &&
    $past(pattern_enable_i[0]) |-> tx_line_tip_o[0] == $past(pattern_bit_i[0]))
    else $error("line route wrong");
  a_route_rx: assert property (st0 && s0_r[6] &&
    $past(pattern_enable_i[0]) |-> !rx_negative_data_o[0] &&
    rx_positive_data_o[0] == $past(pattern_bit_i[0])) else $error("rx route");
  a_cfg_reset: assert property ($past(srst_i) |->
    chan_cfg_o == '0) else $error("config not cleared");
  a_pin_off: assert property (!rx_global_enable_i [*8] |->
    !c0.rx_power) else $error("receiver on with pin low");
  a_pin_on: assert property (rx_global_enable_i [*8] ##0 st0 |->
    c0.rx_power == s0_r[5]) else $error("receiver power wrong");
  a_t1_codes: assert property (st0 && s0_r[4:0] inside {[8:13]} |->
    c0.line_mode == LCR_MODE_T1 && c0.lbo_step == s0_r[2:0] && !c0.hdb3)
    else $error("t1 decode wrong");
  a_rsvd_code: assert property (st0 &&
    !(s0_r[4:0] inside {[8:13], 28, 29}) |-> c0.eq_reserved &&
    c0.line_mode == LCR_MODE_T1) else $error("reserved decode wrong");
  a_term_imp: assert property (st1 |->
    c0.rx_term == s1_r[7] && c0.tx_term == s1_r[6] &&
    c0.rx_imp == lcr_imp_e'(s1_r[5:4])) else $error("termination wrong");
  a_ja_path: assert property (st1 |-> c0.ja_path ==
    (s1_r[3:2] == 2'h0 ? LCR_JA_OFF : s1_r[3:2] == 2'h1 ? LCR_JA_TX :
    LCR_JA_RX)) else $error("ja");
  // Main scenarios reached
  cover property (st0 && s0_r[6] && pattern_enable_i[0]);
  cover property (st0 && c0.line_mode == LCR_MODE_E1);
  cover property (rx_global_enable_i && c0.rx_power);
endmodule : lcr_regs_asserts
bind lcr_regs lcr_regs_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .rx_global_enable_i(rx_global_enable_i),
  .pattern_enable_i(pattern_enable_i), .pattern_bit_i(pattern_bit_i),
  .tx_line_tip_o(tx_line_tip_o), .rx_positive_data_o(rx_positive_data_o),
  .rx_negative_data_o(rx_negative_data_o), .chan_cfg_o(chan_cfg_o));

/* test/lcr_line_model.sv */
`timescale 1ns/1ps
module lcr_line_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Received marks; never both at once, changing every cycle
  output logic [7:0] rx_pos_o,
  output logic [7:0] rx_neg_o
);
  // Stale data never matches by chance
  always_ff @(posedge core_clk_i) begin
    if (srst_i) {rx_pos_o, rx_neg_o} <= {8'h5A, 8'h00};
    else {rx_pos_o, rx_neg_o} <= {~rx_pos_o, rx_pos_o};
  end
endmodule : lcr_line_model

/* test/test_liu_channel_line_config_regs.sv */
`timescale 1ns/1ps
module test_liu_channel_line_config_regs import lcr_pkg::*;;
  logic core_clk_i, srst_i, reg_wr_i, reg_rd_i, rx_global_enable_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pattern_enable_i;
  logic [7:0] pattern_bit_i, tx_data_i, rx_pos_data_i, rx_neg_data_i;
  logic [7:0] tx_line_tip_o, tx_line_ring_o, rx_positive_data_o;
  logic [7:0] rx_negative_data_o, pattern_kind_select_o;
  lcr_chan_cfg_s [7:0] chan_cfg_o;
  lcr_chan_cfg_s e;
  logic [15:0] p;
  int n_mismatch = 0;
  int checks_done = 0;
  lcr_regs u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .rx_global_enable_i(rx_global_enable_i),
    .pattern_enable_i(pattern_enable_i), .pattern_bit_i(pattern_bit_i),
    .tx_data_i(tx_data_i), .rx_pos_data_i(rx_pos_data_i),
    .rx_neg_data_i(rx_neg_data_i), .tx_line_tip_o(tx_line_tip_o),
    .tx_line_ring_o(tx_line_ring_o),
    .rx_positive_data_o(rx_positive_data_o),
    .rx_negative_data_o(rx_negative_data_o),
    .pattern_kind_select_o(pattern_kind_select_o),
    .chan_cfg_o(chan_cfg_o));
  lcr_line_model u_line (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .rx_pos_o(rx_pos_data_i), .rx_neg_o(rx_neg_data_i));
  initial begin
    core_clk_i = 0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task step;
    @(posedge core_clk_i);
    #2;
  endtask : step
  task chk(string n, logic [15:0] s, logic [15:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // Strobe drops for one cycle so back-to-back calls stay distinct
  task wr_reg(logic [7:0] a, logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    step;
    reg_wr_i = 0;
    step;
  endtask : wr_reg
  task rd_reg(logic [7:0] a, logic [7:0] x, string n);
    reg_addr_i = a;
    reg_rd_i = 1;
    step;
    reg_rd_i = 0;
    step;
    chk(n, 16'(reg_rdata_o), 16'(x));
  endtask : rd_reg
  task stop_test;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    {reg_wr_i, reg_rd_i, rx_global_enable_i, reg_addr_i, reg_wdata_i} = '0;
    {pattern_enable_i, pattern_bit_i, tx_data_i} = '0;
    srst_i = 1;
    repeat (20) step;
    srst_i = 0;
    rd_reg(8'h00, 8'h00, "reg0");
    rd_reg(8'h01, 8'h00, "reg1");
    // Every code, receiver bit set while the pin is still low
    for (int c = 0; c < 32; c++) begin
      wr_reg(8'h00, 8'h20 | 8'(c));
      step;
      e = '0;
      if (c inside {[8:13]}) e.lbo_step = 3'(c);
      else if (c == 28 || c == 29) begin
        e.line_mode = LCR_MODE_E1;
        e.hdb3 = 1;
        e.coax = !c[0];
      end
      else e.eq_reserved = 1;
      chk("cfg", 16'(chan_cfg_o[0]), 16'(e));
    end
    rx_global_enable_i = 1;
    repeat (6) step;
    chk("power", 16'(chan_cfg_o[0].rx_power), 16'h0001);
    for (int v = 0; v < 64; v++) begin
      wr_reg(8'h01, 8'(v << 2));
      step;
      chk("term", 16'({chan_cfg_o[0].rx_term,
        chan_cfg_o[0].tx_term, chan_cfg_o[0].rx_imp, chan_cfg_o[0].ja_path}),
        16'({v[5:2], v[1:0] == 0 ? 2'h0 : v[1] ? 2'h2 : 2'h1}));
      rd_reg(8'h01, 8'(v << 2), "reg1");
    end
    wr_reg(8'h00, 8'h80);
    step;
    chk("kind", 16'(pattern_kind_select_o), 16'h0001);
    pattern_enable_i = 8'h01;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        wr_reg(8'h00, 8'hC0);
        step;
      end
      pattern_bit_i = {8{k[0]}};
      tx_data_i = ~pattern_bit_i;
      step;
      if (k < 4) begin
        chk("tip", 16'(tx_line_tip_o[1:0]), 16'({~k[0], k[0]}));
        chk("ring", 16'(tx_line_ring_o[1:0]), 16'({k[0], ~k[0]}));
      end else begin
        chk("rx", 16'({rx_negative_data_o[0], rx_positive_data_o[0]}),
          16'(k[0]));
      end
    end
    pattern_enable_i = 8'h00;
    wr_reg(8'h00, 8'h80);
    p = {rx_neg_data_i, rx_pos_data_i};
    step;
    chk("rxdata", {rx_negative_data_o, rx_positive_data_o}, p);
    wr_reg(8'h80, 8'hFF);
    rd_reg(8'h80, 8'h00, "unmapped");
    rd_reg(8'h00, 8'h80, "reg0");
    // Pin gates the receiver bit in both directions
    wr_reg(8'h00, 8'hA0);
    step;
    chk("power on", 16'(chan_cfg_o[0].rx_power), 16'h0001);
    rx_global_enable_i = 0;
    repeat (6) step;
    chk("power off", 16'(chan_cfg_o[0].rx_power), 16'h0000);
    // Top channel decodes alone; channel 0 keeps its value
    wr_reg(8'h71, 8'hA4);
    step;
    rd_reg(8'h71, 8'hA4, "ch7 reg1");
    chk("ch7 term", 16'({chan_cfg_o[7].rx_term,
      chan_cfg_o[7].tx_term, chan_cfg_o[7].rx_imp, chan_cfg_o[7].ja_path}),
      16'h0029);
    rd_reg(8'h01, 8'hFC, "reg1 ch0");
    // Reset in mid-run returns every register to its power-up value
    srst_i = 1;
    repeat (2) step;
    srst_i = 0;
    rd_reg(8'h00, 8'h00, "reg0 rst");
    rd_reg(8'h01, 8'h00, "reg1 rst");
    e = '0;
    e.eq_reserved = 1;
    chk("cfg rst", 16'(chan_cfg_o[0]), 16'(e));
    stop_test;
  end
  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    stop_test;
  end
endmodule : test_liu_channel_line_config_regs
